//--- verilog/rcm_pkg.sv
package rcm_pkg;
   // Register port
   localparam int ADDR_W = 4;
   localparam int DATA_W = 8;
   localparam logic [ADDR_W-1:0] REG_OPTION = 4'h0;
   localparam logic [ADDR_W-1:0] REG_STATUS = 4'h1;

   // Option register fields
   localparam int OPT_LONG_DELAY = 0;
   localparam int OPT_MULT_EN = 1;
   localparam int OPT_SRC_LSB = 2;
   localparam int OPT_GUARD_EN = 5;
   localparam int OPT_LSD_EN = 6;
   localparam logic [DATA_W-1:0] OPTION_RST = 8'h45;

   // Status register fields
   localparam int ST_PHASE_LSB = 0;
   localparam int ST_EXT_FLAG = 2;
   localparam int ST_LSD_FLAG = 3;
   localparam int ST_WDG_FLAG = 4;

   // Timing
   localparam int CLK_PERIOD_NS = 50;
   localparam int CNT_W = 13;
   localparam logic [CNT_W-1:0] SHORT_DELAY_CYC = 13'h0100;
   localparam logic [CNT_W-1:0] LONG_DELAY_CYC = 13'h1000;
   localparam logic [CNT_W-1:0] FETCH_CYC = 13'h0002;
   // Minimum watchdog pulse on the pin; plain default, tune per process
   localparam int WDG_PULSE_NS = 500;
   localparam logic [CNT_W-1:0] WDG_PULSE_CYC =
      CNT_W'((WDG_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
   localparam logic [1:0] SYNC_SETTLE = 2'h3;

   // Reset vector location
   localparam logic [15:0] VEC_LO = 16'hfffe;
   localparam logic [15:0] VEC_HI = 16'hffff;

   typedef enum logic [1:0] {
      PH_RUN = 2'b00,
      PH_ACTIVE = 2'b01,
      PH_DELAY = 2'b10,
      PH_FETCH = 2'b11
   } rcm_phase_t;

   typedef enum logic [2:0] {
      OSC_EXT = 3'b000,
      OSC_RES0 = 3'b001,
      OSC_RES1 = 3'b010,
      OSC_RES2 = 3'b011,
      OSC_RES3 = 3'b100,
      OSC_RES4 = 3'b101,
      OSC_RC = 3'b110
   } rcm_osc_t;
endpackage : rcm_pkg

//--- verilog/rcm_count_if.sv
interface rcm_count_if;
   import rcm_pkg::*;
   logic load;
   logic [CNT_W-1:0] load_val;
   logic done;
   modport ctrl (output load, output load_val, input done);
   modport cnt (input load, input load_val, output done);
endinterface : rcm_count_if

//--- verilog/rcm_down_counter.sv
module rcm_down_counter
   import rcm_pkg::*;
(
   // Clock and reset
   input wire logic i_clk,
   input wire logic i_rst,
   // Control from the sequencer
   rcm_count_if.cnt cif
);
   logic [CNT_W-1:0] count;
   logic [CNT_W-1:0] next_count;

   // Loading N-1 makes the phase last N cycles
   always_comb begin
      if (cif.load) begin
         next_count = cif.load_val;
      end else if (count != '0) begin
         next_count = count - 1'b1;
      end else begin
         next_count = count;
      end
   end

   always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         count <= '0;
      end else begin
         count <= next_count;
      end
   end

   assign cif.done = (count == '0);
endmodule : rcm_down_counter

//--- verilog/rcm_reset_clock_mgr.sv
// Behaviour
// - Pin, supply and watchdog causes all pull the reset pin; pin low in delay.
// - After reset, the vector is fetched from the top two memory bytes.
// - Each reset runs active phase, then stabilisation delay, then vector fetch.
// - Option bit picks short or long delay to match oscillator start-up.
// - Delay counts 256 or 4096 CPU cycles before the reset phase ends.
// - Vector fetch lasts exactly two cycles after the delay expires.
// - Reset pin is open drain with pull-up; device only drives it low.
// - Low external pin is caught without a running clock.
// - Low supply reported drives the reset pin low.
// - Watchdog underflow drives the pin low for a minimum pulse time.
// - Enabled multiplier gives an intermediate clock at twice the input rate.
// - Option enables multiplier; otherwise intermediate clock is oscillator halved.
// - Multiplier is never used with the internal RC oscillator.
// - Option selects external clock, one of five resonators, or internal RC.
// - Resonators keep running throughout the reset phase, but not while i_rst is held.
// - Option bit enables the clock guard with filter and safe oscillator.
// - Low supply detector is optional; its cause is ignored when off.
module rcm_reset_clock_mgr
   import rcm_pkg::*;
(
   // Clock and reset
   input wire logic i_clk,
   input wire logic i_rst,
   // Register port
   input wire logic [ADDR_W-1:0] i_addr,
   input wire logic [DATA_W-1:0] i_wdata,
   input wire logic i_wr,
   input wire logic i_rd,
   output logic [DATA_W-1:0] o_rdata,
   // Reset causes
   input wire logic i_low_supply,
   input wire logic i_wdg_underflow,
   // Open-drain reset pin
   input wire logic i_rst_pin_in,
   output logic o_rst_pin_out,
   output logic o_rst_pin_oe,
   // CPU side
   output logic o_cpu_reset,
   output logic o_vec_fetch,
   output logic [15:0] o_vec_addr,
   // Clock management
   input wire logic i_osc_in_pin,
   output logic [2:0] o_osc_source,
   output logic o_resonator_run,
   output logic o_mult_on,
   output logic o_clock_guard_en,
   output logic o_intermediate_clock
);
   rcm_count_if cif ();

   rcm_down_counter u_counter (
      .i_clk(i_clk),
      .i_rst(i_rst),
      .cif(cif.cnt)
   );

   // External pin catch: preset by the pin itself, so a halted clock still sees it
   logic ext_catch;
   logic ext_sync1;
   logic ext_sync2;

   always_ff @(posedge i_clk or posedge i_rst or negedge i_rst_pin_in) begin
      if (i_rst) begin
         ext_catch <= 1'b1; // Our own drive holds the pin low through reset
      end else if (!i_rst_pin_in) begin
         ext_catch <= 1'b1;
      end else begin
         ext_catch <= 1'b0;
      end
   end

   always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         ext_sync1 <= 1'b0;
         ext_sync2 <= 1'b0;
      end else begin
         ext_sync1 <= ext_catch;
         ext_sync2 <= ext_sync1;
      end
   end

   // Registers
   logic [DATA_W-1:0] option;
   logic [DATA_W-1:0] next_option;
   logic ext_flag;
   logic lsd_flag;
   logic wdg_flag;
   logic next_ext_flag;
   logic next_lsd_flag;
   logic next_wdg_flag;
   logic [DATA_W-1:0] next_rdata;

   logic opt_long;
   logic opt_mult;
   logic opt_guard;
   logic opt_lsd;
   logic [2:0] opt_src;

   assign opt_long = option[OPT_LONG_DELAY];
   assign opt_mult = option[OPT_MULT_EN];
   assign opt_guard = option[OPT_GUARD_EN];
   assign opt_lsd = option[OPT_LSD_EN];
   assign opt_src = option[OPT_SRC_LSB +: 3];

   // Sequencer state
   rcm_phase_t phase;
   rcm_phase_t next_phase;
   logic [1:0] settle;
   logic [1:0] next_settle;
   logic ext_req;
   logic lsd_req;
   logic wdg_req;
   logic req_any;
   logic next_pin_oe;
   logic next_cpu_reset;
   logic next_vec_fetch;
   logic [15:0] next_vec_addr;

   // Our own drive reads back on the pin, so ignore the pin until it has had
   // time to rise and pass the synchroniser after release
   assign ext_req = ext_sync2 && (settle == SYNC_SETTLE);
   assign lsd_req = i_low_supply && opt_lsd;
   assign wdg_req = i_wdg_underflow;
   assign req_any = ext_req || lsd_req || wdg_req;

   always_comb begin
      next_phase = phase;
      cif.load = 1'b0;
      cif.load_val = '0;
      if (req_any) begin
         // Any new cause restarts from the active phase
         next_phase = PH_ACTIVE;
         cif.load = 1'b1;
         cif.load_val = wdg_req ? (WDG_PULSE_CYC - 1'b1) : '0;
      end else begin
         case (phase)
            PH_ACTIVE: begin
               if (cif.done) begin
                  next_phase = PH_DELAY;
                  cif.load = 1'b1;
                  cif.load_val = opt_long ? (LONG_DELAY_CYC - 1'b1)
                                          : (SHORT_DELAY_CYC - 1'b1);
               end
            end
            PH_DELAY: begin
               if (cif.done) begin
                  next_phase = PH_FETCH;
                  cif.load = 1'b1;
                  cif.load_val = FETCH_CYC - 1'b1;
               end
            end
            PH_FETCH: begin
               if (cif.done) begin
                  next_phase = PH_RUN;
               end
            end
            PH_RUN: begin
               next_phase = PH_RUN;
            end
            default: begin
               next_phase = PH_ACTIVE;
            end
         endcase
      end
   end

   always_comb begin
      next_pin_oe = (next_phase == PH_ACTIVE) || (next_phase == PH_DELAY);
      next_cpu_reset = next_pin_oe;
      next_vec_fetch = (next_phase == PH_FETCH);
      next_vec_addr = (phase == PH_FETCH) ? VEC_HI : VEC_LO;
      if (o_rst_pin_oe) begin
         next_settle = 2'h0;
      end else if (settle != SYNC_SETTLE) begin
         next_settle = settle + 2'h1;
      end else begin
         next_settle = settle;
      end
   end

   // Power-up starts in the active phase so a full delay always runs
   always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         phase <= PH_ACTIVE;
         settle <= 2'h0;
         o_rst_pin_oe <= 1'b1;
         o_rst_pin_out <= 1'b0;
         o_cpu_reset <= 1'b1;
         o_vec_fetch <= 1'b0;
         o_vec_addr <= VEC_LO;
      end else begin
         phase <= next_phase;
         settle <= next_settle;
         o_rst_pin_oe <= next_pin_oe;
         o_rst_pin_out <= 1'b0;
         o_cpu_reset <= next_cpu_reset;
         o_vec_fetch <= next_vec_fetch;
         o_vec_addr <= next_vec_addr;
      end
   end

   // Register port; a cause that lands with its clear keeps its flag
   always_comb begin
      next_option = option;
      next_ext_flag = ext_flag;
      next_lsd_flag = lsd_flag;
      next_wdg_flag = wdg_flag;
      next_rdata = '0;
      if (i_wr && (i_addr == REG_OPTION)) begin
         next_option = i_wdata;
      end
      if (i_wr && (i_addr == REG_STATUS)) begin
         next_ext_flag = ext_flag && !i_wdata[ST_EXT_FLAG];
         next_lsd_flag = lsd_flag && !i_wdata[ST_LSD_FLAG];
         next_wdg_flag = wdg_flag && !i_wdata[ST_WDG_FLAG];
      end
      if (ext_req) begin
         next_ext_flag = 1'b1;
      end
      if (lsd_req) begin
         next_lsd_flag = 1'b1;
      end
      if (wdg_req) begin
         next_wdg_flag = 1'b1;
      end
      if (i_rd) begin
         case (i_addr)
            REG_OPTION: begin
               next_rdata = option;
            end
            REG_STATUS: begin
               next_rdata[ST_PHASE_LSB +: 2] = phase;
               next_rdata[ST_EXT_FLAG] = ext_flag;
               next_rdata[ST_LSD_FLAG] = lsd_flag;
               next_rdata[ST_WDG_FLAG] = wdg_flag;
            end
            default: begin
               next_rdata = '0;
            end
         endcase
      end
   end

   always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         option <= OPTION_RST;
         ext_flag <= 1'b0;
         lsd_flag <= 1'b0;
         wdg_flag <= 1'b0;
         o_rdata <= '0;
      end else begin
         option <= next_option;
         ext_flag <= next_ext_flag;
         lsd_flag <= next_lsd_flag;
         wdg_flag <= next_wdg_flag;
         o_rdata <= next_rdata;
      end
   end
   // Clock selection; the oscillator pin is sampled, so doubling yields one
   // high cycle per input edge rather than a true analog multiplier output
   logic osc_q;
   logic osc_prev;
   logic osc_edge;
   logic osc_rise;
   logic src_is_res;
   logic next_mult_on;
   logic next_iclk;
   assign osc_edge = osc_q ^ osc_prev;
   assign osc_rise = osc_q && !osc_prev;
   always_comb begin
      case (opt_src)
         OSC_RES0, OSC_RES1, OSC_RES2, OSC_RES3, OSC_RES4: begin
            src_is_res = 1'b1;
         end
         default: begin
            src_is_res = 1'b0;
         end
      endcase
      next_mult_on = opt_mult && (opt_src != OSC_RC);
      if (next_mult_on) begin
         next_iclk = osc_edge;
      end else if (osc_rise) begin
         next_iclk = !o_intermediate_clock;
      end else begin
         next_iclk = o_intermediate_clock;
      end
   end

   always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         osc_q <= 1'b0;
         osc_prev <= 1'b0;
         o_osc_source <= OSC_EXT;
         o_resonator_run <= 1'b0;
         o_mult_on <= 1'b0;
         o_clock_guard_en <= 1'b0;
         o_intermediate_clock <= 1'b0;
      end else begin
         osc_q <= i_osc_in_pin;
         osc_prev <= osc_q;
         o_osc_source <= opt_src;
         o_resonator_run <= src_is_res;
         o_mult_on <= next_mult_on;
         o_clock_guard_en <= opt_guard;
         o_intermediate_clock <= next_iclk;
      end
   end
   // Checks
   default clocking cb @(posedge i_clk);
   endclocking
   default disable iff (i_rst);
   logic [CNT_W-1:0] dly_len;
   logic [CNT_W-1:0] dly_exp;
   always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         dly_len <= '0;
         dly_exp <= '0;
      end else if (phase != PH_DELAY) begin
         dly_len <= '0;
         dly_exp <= opt_long ? (LONG_DELAY_CYC - 1'b1) : (SHORT_DELAY_CYC - 1'b1);
      end else begin
         dly_len <= dly_len + 1'b1;
      end
   end
   a_pin_low_delay: assert property (
      (phase == PH_DELAY) |-> (o_rst_pin_oe && !o_rst_pin_out))
      else $error("reset pin not driven low during delay");
   a_vector_order: assert property (
      $rose(o_vec_fetch) |-> (o_vec_addr == VEC_LO) ##1
         (!o_vec_fetch || (o_vec_addr == VEC_HI)))
      else $error("vector fetch address order wrong");
   a_phase_order: assert property (
      (phase == PH_FETCH) && ($past(phase) != PH_FETCH) |-> ($past(phase) == PH_DELAY))
      else $error("fetch entered without delay");
   a_delay_length: assert property (
      (phase == PH_DELAY) && (next_phase == PH_FETCH) |-> (dly_len == dly_exp))
      else $error("stabilisation delay length wrong");
   a_fetch_two: assert property (
      (phase == PH_FETCH) && ($past(phase) == PH_FETCH) |=> (phase != PH_FETCH))
      else $error("vector fetch longer than two cycles");
   a_never_high: assert property (
      o_rst_pin_oe |-> !o_rst_pin_out)
      else $error("reset pin driven high");
   a_ext_caught: assert property (
      !i_rst_pin_in |-> ext_catch)
      else $error("low reset pin not caught");
   a_supply_drive: assert property (
      (i_low_supply && opt_lsd) |=> o_rst_pin_oe)
      else $error("low supply did not drive pin");
   a_wdg_pulse: assert property (
      i_wdg_underflow |=> o_rst_pin_oe [*8])
      else $error("watchdog pulse too short");
   a_mult_rc: assert property (
      (o_osc_source == OSC_RC) |-> !o_mult_on)
      else $error("multiplier used with RC oscillator");
   a_restart_delay: assert property (
      (phase == PH_DELAY) && req_any |=> (phase == PH_ACTIVE))
      else $error("new request did not restart");
   a_cpu_held: assert property (
      ((phase == PH_ACTIVE) || (phase == PH_DELAY)) |-> o_cpu_reset)
      else $error("cpu released early");
   c_full_seq: cover property ((phase == PH_FETCH) ##1 (phase == PH_FETCH) ##1 (phase == PH_RUN));
   c_wdg_reset: cover property ((phase == PH_RUN) ##1 i_wdg_underflow);
   c_ext_reset: cover property ((phase == PH_RUN) && ext_req);
   c_short_delay: cover property ((phase == PH_DELAY) && !opt_long && cif.done);
endmodule : rcm_reset_clock_mgr

//--- verification/rcm_board_model.sv
module rcm_board_model (
   // Device side of the reset pin
   input wire logic i_pin_out,
   input wire logic i_pin_oe,
   // Board controls
   input wire logic i_pull_low,
   input wire logic i_osc_run,
   // Board outputs
   output logic o_pin_level,
   output logic o_osc
);
   timeunit 1ns;
   timeprecision 1ps;

   // Open drain with pull-up: either party can only pull low
   assign o_pin_level = ((i_pin_oe && !i_pin_out) || i_pull_low) ? 1'b0 : 1'b1;

   // Oscillator period of 7 CPU cycles, free of the CPU clock phase
   // Offset keeps every toggle away from a CPU clock edge
   initial begin
      o_osc = 1'b0;
      #12;
      forever begin
         #175;
         o_osc = i_osc_run ? ~o_osc : 1'b0;
      end
   end
endmodule : rcm_board_model

//--- verification/rcm_reset_clock_mgr_tb.sv
`define CHK(nm, exp, got) begin total_checks++; if ((got) !== (exp)) begin bad_count++; \
   $display("ERROR %s expected %0h seen %0h", nm, exp, got); end end

module rcm_reset_clock_mgr_tb
   import rcm_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;

   logic clk = 1'b0;
   logic i_rst = 1'b1;
   logic [ADDR_W-1:0] i_addr = '0;
   logic [DATA_W-1:0] i_wdata = '0;
   logic i_wr = 1'b0;
   logic i_rd = 1'b0;
   logic i_low_supply = 1'b0;
   logic i_wdg_underflow = 1'b0;
   logic pull_low = 1'b0;
   logic osc_run = 1'b1;
   logic [DATA_W-1:0] o_rdata;
   logic o_rst_pin_out, o_rst_pin_oe, o_cpu_reset, o_vec_fetch;
   logic [15:0] o_vec_addr;
   logic [2:0] o_osc_source;
   logic o_resonator_run, o_mult_on, o_clock_guard_en, o_intermediate_clock;
   logic pin_level, osc;
   logic pin_gap = 1'b0;
   logic res_lost = 1'b0;
   int bad_count = 0;
   int total_checks = 0;

   always #25 clk = ~clk;

   rcm_board_model i_board (.i_pin_out(o_rst_pin_out), .i_pin_oe(o_rst_pin_oe),
      .i_pull_low(pull_low), .i_osc_run(osc_run), .o_pin_level(pin_level), .o_osc(osc));

   rcm_reset_clock_mgr i_dut (.i_clk(clk), .i_rst(i_rst), .i_addr(i_addr),
      .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata),
      .i_low_supply(i_low_supply), .i_wdg_underflow(i_wdg_underflow),
      .i_rst_pin_in(pin_level), .o_rst_pin_out(o_rst_pin_out), .o_rst_pin_oe(o_rst_pin_oe),
      .o_cpu_reset(o_cpu_reset), .o_vec_fetch(o_vec_fetch), .o_vec_addr(o_vec_addr),
      .i_osc_in_pin(osc), .o_osc_source(o_osc_source), .o_resonator_run(o_resonator_run),
      .o_mult_on(o_mult_on), .o_clock_guard_en(o_clock_guard_en),
      .o_intermediate_clock(o_intermediate_clock));

   task automatic final_report;
      $display("checks %0d mismatches %0d", total_checks, bad_count);
      if (bad_count == 0 && total_checks > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask : final_report

   task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
      @(posedge clk);
      i_addr <= a;
      i_wdata <= d;
      i_wr <= 1'b1;
      @(posedge clk);
      i_wr <= 1'b0;
   endtask : wr

   task automatic rd_chk(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] exp);
      @(posedge clk);
      i_addr <= a;
      i_rd <= 1'b1;
      @(posedge clk);
      i_rd <= 1'b0;
      #1;
      `CHK("rdata", exp, o_rdata)
   endtask : rd_chk

   // One-cycle underflow; the design takes it at the edge that lowers it, so
   // a count started afterwards misses the first reset cycle
   task automatic wdg_pulse;
      @(posedge clk);
      i_wdg_underflow <= 1'b1;
      @(posedge clk);
      i_wdg_underflow <= 1'b0;
   endtask : wdg_pulse

   // Counts reset cycles until the fetch, then checks the two fetch cycles
   task automatic wait_seq(output int n);
      int k;
      n = 0;
      for (k = 0; k < 6000; k++) begin
         @(posedge clk);
         #1;
         if (o_rst_pin_out !== 1'b0) pin_gap = 1'b1;
         if (o_cpu_reset === 1'b1 && o_rst_pin_oe !== 1'b1) pin_gap = 1'b1;
         if (o_cpu_reset === 1'b1 && o_resonator_run !== 1'b1) res_lost = 1'b1;
         if (o_vec_fetch === 1'b1) break;
         if (o_cpu_reset === 1'b1) n++;
      end
      `CHK("vec_first", VEC_LO, o_vec_addr)
      `CHK("cpu_released", 1'b0, o_cpu_reset)
      `CHK("pin_released", 1'b0, o_rst_pin_oe)
      @(posedge clk);
      #1;
      `CHK("vec_second", VEC_HI, o_vec_addr)
      `CHK("fetch_held", 1'b1, o_vec_fetch)
      @(posedge clk);
      #1;
      `CHK("fetch_over", 1'b0, o_vec_fetch)
   endtask : wait_seq

   task automatic count_clk(input logic edges, output int c);
      logic last;
      #1;
      last = o_intermediate_clock;
      c = 0;
      repeat (70) begin
         @(posedge clk);
         #1;
         if (edges ? (o_intermediate_clock !== last) : (o_intermediate_clock === 1'b1)) c++;
         last = o_intermediate_clock;
      end
   endtask : count_clk

   initial begin
      int n;
      logic [2:0] s;
      repeat (10) @(posedge clk);
      i_rst <= 1'b0;
      wait_seq(n);
      res_lost = 1'b0;
      rd_chk(REG_OPTION, OPTION_RST);
      rd_chk(4'h7, 8'h00);
      // Doubled clock: one pulse per osc edge; halved: one toggle per rising edge
      wr(REG_OPTION, 8'h46);
      count_clk(1'b0, n);
      `CHK("doubled", 1'b1, n >= 19 && n <= 21)
      wr(REG_OPTION, 8'h44);
      count_clk(1'b1, n);
      `CHK("halved", 1'b1, n >= 9 && n <= 11)
      for (int i = 0; i < 7; i++) begin
         s = 3'(i);
         wr(REG_OPTION, {2'b01, s[0], s, 2'b10});
         repeat (3) @(posedge clk);
         #1;
         `CHK("source", s, o_osc_source)
         `CHK("res_run", s >= 3'h1 && s <= 3'h5, o_resonator_run)
         `CHK("mult", s != 3'h6, o_mult_on)
         `CHK("guard", s[0], o_clock_guard_en)
      end
      wr(REG_OPTION, 8'h46);
      wr(REG_STATUS, 8'h1c);
      wdg_pulse();
      wait_seq(n);
      `CHK("wdg_short", int'(WDG_PULSE_CYC + SHORT_DELAY_CYC) - 1, n)
      rd_chk(REG_STATUS, 8'h10);
      wdg_pulse();
      repeat (100) @(posedge clk);
      wdg_pulse();
      wait_seq(n);
      `CHK("restart", int'(WDG_PULSE_CYC + SHORT_DELAY_CYC) - 1, n)
      wr(REG_OPTION, 8'h47);
      wdg_pulse();
      wait_seq(n);
      `CHK("wdg_long", int'(WDG_PULSE_CYC + LONG_DELAY_CYC) - 1, n)
      wr(REG_OPTION, 8'h46);
      wr(REG_STATUS, 8'h1c);
      @(posedge clk);
      i_low_supply <= 1'b1;
      repeat (20) @(posedge clk);
      i_low_supply <= 1'b0;
      wait_seq(n);
      `CHK("supply_len", int'(SHORT_DELAY_CYC), n)
      rd_chk(REG_STATUS, 8'h08);
      wr(REG_OPTION, 8'h06);
      @(posedge clk);
      i_low_supply <= 1'b1;
      n = 0;
      repeat (20) begin
         @(posedge clk);
         #1;
         if (o_rst_pin_oe !== 1'b0) n++;
      end
      `CHK("supply_off", 0, n)
      @(posedge clk);
      i_low_supply <= 1'b0;
      wr(REG_STATUS, 8'h1c);
      @(posedge clk);
      pull_low <= 1'b1;
      repeat (4) @(posedge clk);
      #1;
      `CHK("ext_seen", 1'b1, o_rst_pin_oe)
      repeat (26) @(posedge clk);
      pull_low <= 1'b0;
      wait_seq(n);
      // The pull began 30 cycles before the count started
      `CHK("ext_delay", 1'b1, n + 30 >= 256 && n + 30 <= 262)
      rd_chk(REG_STATUS, 8'h04);
      `CHK("pin_low_all", 1'b0, pin_gap)
      `CHK("res_kept", 1'b0, res_lost)
      final_report();
   end

   initial begin
      #(CLK_PERIOD_NS * 30000);
      bad_count++;
      final_report();
   end
endmodule : rcm_reset_clock_mgr_tb
